//--- inc/guard_lock_pkg.sv
package guard_lock_pkg;
  localparam int CODE_W = 32;
  localparam logic [CODE_W-1:0] CODE_RESET = 32'h0000_0000;
  localparam int CLK_MHZ = 50;
  localparam int ENERGIZE_NS = 2000;
  localparam int ENERGIZE_CYC = (ENERGIZE_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] ENERGIZE_CNT = CNT_W'(ENERGIZE_CYC);
  localparam int SYNC_W = 8;
  localparam int IN_HOLD = 0;
  localparam int IN_CLOSED = 1;
  localparam int IN_RELEASE = 2;
  localparam int IN_AUX = 3;
  localparam int IN_STUCK = 4;
  localparam int IN_TENSION = 5;
  localparam int IN_SOLV = 6;
  localparam int IN_LINKED = 7;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_POWER = 4'b0010,
    ST_READ = 4'b0100,
    ST_PRESENT = 4'b1000
  } detect_t;
endpackage

//--- rtl/pin_sync.sv
module pin_sync
  import guard_lock_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic pin_in,
  output logic level_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_out <= 1'b0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // change accepted when stages two and three agree
      if (s2_reg == s3_reg) begin
        level_out <= s3_reg;
      end
    end
  end
endmodule

//--- rtl/guard_lock_ctrl.sv
module guard_lock_ctrl
  import guard_lock_pkg::*;
#(
  parameter bit EXACT_CODE = 1'b1
)
(
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  input wire logic ACTUATOR_NEAR_IN,
  input wire logic TAG_VALID_IN,
  input wire logic [guard_lock_pkg::CODE_W-1:0] TAG_CODE_IN,
  input wire logic TEACH_IN,
  input wire logic CLOSED_IN,
  input wire logic RELEASE_REQUEST_INPUT_IN,
  input wire logic COMM_MODE_IN,
  input wire logic LOCK_COMMAND_BIT_IN,
  input wire logic AUX_RELEASE_IN,
  input wire logic ELEMENT_STUCK_IN,
  input wire logic TENSION_IN,
  input wire logic SOLENOID_OK_IN,
  input wire logic GATEWAY_LINKED_IN,
  input wire logic INTERNAL_FAULT_IN,
  input wire logic [7:0] COMM_DATA_IN,
  input wire logic SUPPLY_OK_IN,
  output logic ENERGIZE_OUT,
  output logic SAFE_OUTPUT_A_OUT,
  output logic SAFE_OUTPUT_B_OUT,
  output logic LOCK_STATE_FLAG_OUT,
  output logic DOOR_CLOSED_FLAG_OUT,
  output logic FAULT_FLAG_OUT,
  output logic FAULT_INDICATOR_OUT,
  output logic OUTPUTS_ACTIVE_FLAG_OUT,
  output logic STUCK_ELEMENT_FLAG_OUT,
  output logic COMM_OUT,
  output logic [guard_lock_pkg::CODE_W-1:0] TAUGHT_CODE_OUT
);
  import guard_lock_pkg::*;

  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] pin;
  logic near_s;
  logic fault_s;
  logic supply_s;
  assign raw = {GATEWAY_LINKED_IN, SOLENOID_OK_IN, TENSION_IN, ELEMENT_STUCK_IN,
                AUX_RELEASE_IN, RELEASE_REQUEST_INPUT_IN, CLOSED_IN, ACTUATOR_NEAR_IN};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      pin_sync u_sync (
        .clk_in(CLK_SYS_IN),
        .rst_in(RST_IN),
        .pin_in(raw[gi]),
        .level_out(pin[gi])
      );
    end
  endgenerate
  pin_sync u_fault (
    .clk_in(CLK_SYS_IN),
    .rst_in(RST_IN),
    .pin_in(INTERNAL_FAULT_IN),
    .level_out(fault_s)
  );
  pin_sync u_supply (
    .clk_in(CLK_SYS_IN),
    .rst_in(RST_IN),
    .pin_in(SUPPLY_OK_IN),
    .level_out(supply_s)
  );
  assign near_s = pin[IN_HOLD];

  logic closed;
  logic req_release;
  logic aux;
  assign closed = pin[IN_CLOSED];
  assign aux = pin[IN_AUX];
  assign req_release = COMM_MODE_IN ? LOCK_COMMAND_BIT_IN : pin[IN_RELEASE];

  // actuator detection
  detect_t det_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CODE_W-1:0] taught_reg;
  logic code_ok;
  assign code_ok = EXACT_CODE ? (TAG_CODE_IN == taught_reg) : 1'b1;

  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      det_reg <= ST_IDLE;
      cnt_reg <= '0;
    end else if (!near_s || !closed) begin
      det_reg <= ST_IDLE;
      cnt_reg <= '0;
    end else begin
      case (det_reg)
        ST_IDLE: begin
          det_reg <= ST_POWER;
          cnt_reg <= '0;
        end
        ST_POWER: begin
          cnt_reg <= cnt_reg + CNT_W'(1);
          if (cnt_reg + CNT_W'(1) >= ENERGIZE_CNT) begin
            det_reg <= ST_READ;
          end
        end
        ST_READ: begin
          if (TAG_VALID_IN && code_ok) begin
            det_reg <= ST_PRESENT;
          end
        end
        ST_PRESENT: begin
          if (TAG_VALID_IN && !code_ok) begin
            det_reg <= ST_READ;
          end
        end
        default: det_reg <= ST_IDLE;
      endcase
    end
  end

  // teach-in stores the read code
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      taught_reg <= CODE_RESET;
    end else if (TEACH_IN && det_reg == ST_READ && TAG_VALID_IN) begin
      taught_reg <= TAG_CODE_IN;
    end
  end

  logic present;
  assign present = (det_reg == ST_PRESENT);

  // lock state, bistable: no reset branch, but cleared during reset as the synchronised closed input is low
  logic lock_reg;
  logic aux_latch_reg;
  logic was_closed_reg;
  logic lock_next;
  // aux release latches until guard reopened
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      aux_latch_reg <= 1'b0;
    end else if (aux) begin
      aux_latch_reg <= 1'b1;
    end else if (!closed) begin
      aux_latch_reg <= 1'b0;
    end
  end

  always_comb begin
    lock_next = lock_reg;
    if (aux || aux_latch_reg || !closed) begin
      lock_next = 1'b0;
    end else if (!supply_s) begin
      lock_next = lock_reg;
    end else if (pin[IN_STUCK]) begin
      lock_next = lock_reg;
    end else if (!was_closed_reg) begin
      lock_next = present && !req_release;
    end else if (req_release) begin
      lock_next = SOLENOID_OK_IN ? 1'b0 : lock_reg;
    end else begin
      lock_next = present;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    lock_reg <= lock_next;
    if (RST_IN) begin
      was_closed_reg <= 1'b1;
    end else if (supply_s) begin
      was_closed_reg <= closed;
    end else begin
      // closing while unpowered leaves the close edge pending until supply returns
      was_closed_reg <= was_closed_reg & closed;
    end
  end

  // door flag validity after aux release
  logic door_valid_reg;
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      door_valid_reg <= 1'b1;
    end else if (aux) begin
      door_valid_reg <= 1'b0;
    end else if (!closed) begin
      door_valid_reg <= 1'b1;
    end
  end

  // fault latch, checked on output demand
  logic fault_reg;
  logic demand;
  assign demand = lock_reg && present;
  // fault caught no later than demand
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      fault_reg <= 1'b0;
    end else if (fault_s || (demand && (SAFE_OUTPUT_A_OUT != SAFE_OUTPUT_B_OUT))) begin
      fault_reg <= 1'b1;
    end
  end

  logic fault_any;
  logic out_on;
  assign fault_any = fault_reg | fault_s;
  // outputs track the next lock state, in step with the lock flag
  assign out_on = lock_next && present && closed && !aux && !fault_any && supply_s;

  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      SAFE_OUTPUT_A_OUT <= 1'b0;
      SAFE_OUTPUT_B_OUT <= 1'b0;
      OUTPUTS_ACTIVE_FLAG_OUT <= 1'b0;
      LOCK_STATE_FLAG_OUT <= 1'b0;
      DOOR_CLOSED_FLAG_OUT <= 1'b0;
      FAULT_FLAG_OUT <= 1'b0;
      FAULT_INDICATOR_OUT <= 1'b0;
      ENERGIZE_OUT <= 1'b0;
    end else begin
      SAFE_OUTPUT_A_OUT <= out_on;
      SAFE_OUTPUT_B_OUT <= out_on;
      OUTPUTS_ACTIVE_FLAG_OUT <= out_on;
      LOCK_STATE_FLAG_OUT <= lock_next && !aux;
      DOOR_CLOSED_FLAG_OUT <= closed && near_s && door_valid_reg;
      FAULT_FLAG_OUT <= fault_any;
      FAULT_INDICATOR_OUT <= fault_any;
      ENERGIZE_OUT <= (det_reg == ST_POWER) || (det_reg == ST_READ) || present;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      STUCK_ELEMENT_FLAG_OUT <= 1'b0;
    end else if (pin[IN_STUCK]) begin
      STUCK_ELEMENT_FLAG_OUT <= 1'b1;
    end else if (!pin[IN_TENSION]) begin
      STUCK_ELEMENT_FLAG_OUT <= 1'b0;
    end
  end

  // comm output: parity of data with gateway, else door monitor
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      COMM_OUT <= 1'b0;
    end else if (pin[IN_LINKED]) begin
      COMM_OUT <= ^COMM_DATA_IN;
    end else begin
      COMM_OUT <= closed && near_s && door_valid_reg;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      TAUGHT_CODE_OUT <= CODE_RESET;
    end else begin
      TAUGHT_CODE_OUT <= taught_reg;
    end
  end

  // assertions
  default clocking @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (RST_IN);

  outputs_equal_a: assert property (SAFE_OUTPUT_A_OUT == SAFE_OUTPUT_B_OUT)
    else $error("safe outputs differ");
  outputs_flag_a: assert property (OUTPUTS_ACTIVE_FLAG_OUT == SAFE_OUTPUT_A_OUT)
    else $error("active flag mismatch");
  unlock_off_a: assert property (!LOCK_STATE_FLAG_OUT |-> !SAFE_OUTPUT_A_OUT)
    else $error("outputs on while unlocked");
  lock_flag_a: assert property (LOCK_STATE_FLAG_OUT |-> lock_reg)
    else $error("lock flag without lock");
  fault_off_a: assert property (
    fault_any |=> !SAFE_OUTPUT_A_OUT && FAULT_INDICATOR_OUT)
    else $error("fault not handled");
  fault_same_a: assert property (FAULT_FLAG_OUT == FAULT_INDICATOR_OUT)
    else $error("fault flag mismatch");
  aux_off_a: assert property (
    aux |=> !SAFE_OUTPUT_A_OUT && !LOCK_STATE_FLAG_OUT)
    else $error("aux release ignored");
  open_release_a: assert property (!closed |=> !lock_reg)
    else $error("locked while open");
  energize_read_a: assert property (det_reg == ST_READ |-> ENERGIZE_OUT)
    else $error("reading without power");
  present_needs_power_a: assert property (
    $rose(present) |-> $past(det_reg) == ST_READ)
    else $error("presence without read");
  hold_unpowered_a: assert property (
    (!supply_s && closed && !aux && !aux_latch_reg) |=> lock_reg == $past(lock_reg))
    else $error("lock lost unpowered");
  stuck_clear_a: assert property (
    (!pin[IN_STUCK] && !pin[IN_TENSION]) |=> !STUCK_ELEMENT_FLAG_OUT)
    else $error("stuck flag held");
  exact_reject_a: assert property (
    (EXACT_CODE && det_reg == ST_READ && TAG_VALID_IN && TAG_CODE_IN != taught_reg)
    |=> !present) else $error("wrong code accepted");

  lock_cov: cover property ($rose(SAFE_OUTPUT_A_OUT));
  aux_cov: cover property (aux && lock_reg);
  fault_cov: cover property ($rose(FAULT_FLAG_OUT));
  stuck_cov: cover property ($rose(STUCK_ELEMENT_FLAG_OUT));
  teach_cov: cover property (TEACH_IN && det_reg == ST_READ && TAG_VALID_IN);
endmodule

//--- verification/guard_ctrl_model.sv
module guard_ctrl_model (
  input wire logic clk_in,
  input wire logic want_lock_in,
  input wire logic safe_out_in,
  output logic release_req_out,
  output logic lock_bit_out,
  output logic plaus_err_out
);
  timeunit 1ns;
  timeprecision 100ps;
  assign release_req_out = !want_lock_in;
  assign lock_bit_out = !want_lock_in;
  always_ff @(posedge clk_in) begin
    plaus_err_out <= want_lock_in ^ safe_out_in;
  end
endmodule

//--- verification/guard_lock_interlock_control_tb.sv
module guard_lock_interlock_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] GOOD = 32'h5A3C_96E1;
  logic clk = 0, rst = 1, near = 0, tvalid = 0, teach = 0, closed = 0, rel, comm = 0, lbit;
  logic aux = 0, stuck = 0, tens = 0, solok = 1, gw = 0, flt = 0, sup = 1, want = 0;
  logic [31:0] code = 32'h0;
  logic [7:0] cdata = 8'hA5;
  logic ener, sa, sb, lck, door, fflag, find, oact, sflag, cout, perr, lck_any;
  logic [31:0] taught;
  int error_cnt = 0;
  int samples_checked = 0;
  always #10 clk = ~clk;
  guard_lock_ctrl i_dut (.CLK_SYS_IN(clk), .RST_IN(rst), .ACTUATOR_NEAR_IN(near),
    .TAG_VALID_IN(tvalid), .TAG_CODE_IN(code), .TEACH_IN(teach), .CLOSED_IN(closed),
    .RELEASE_REQUEST_INPUT_IN(rel), .COMM_MODE_IN(comm), .LOCK_COMMAND_BIT_IN(lbit),
    .AUX_RELEASE_IN(aux), .ELEMENT_STUCK_IN(stuck), .TENSION_IN(tens),
    .SOLENOID_OK_IN(solok), .GATEWAY_LINKED_IN(gw), .INTERNAL_FAULT_IN(flt),
    .COMM_DATA_IN(cdata), .SUPPLY_OK_IN(sup), .ENERGIZE_OUT(ener), .SAFE_OUTPUT_A_OUT(sa),
    .SAFE_OUTPUT_B_OUT(sb), .LOCK_STATE_FLAG_OUT(lck), .DOOR_CLOSED_FLAG_OUT(door),
    .FAULT_FLAG_OUT(fflag), .FAULT_INDICATOR_OUT(find), .OUTPUTS_ACTIVE_FLAG_OUT(oact),
    .STUCK_ELEMENT_FLAG_OUT(sflag), .COMM_OUT(cout), .TAUGHT_CODE_OUT(taught));
  guard_ctrl_model i_ctrl (.clk_in(clk), .want_lock_in(want), .safe_out_in(sa),
    .release_req_out(rel), .lock_bit_out(lbit), .plaus_err_out(perr));
  guard_lock_ctrl #(.EXACT_CODE(1'b0)) i_dut_type (.CLK_SYS_IN(clk), .RST_IN(rst),
    .ACTUATOR_NEAR_IN(near), .TAG_VALID_IN(tvalid), .TAG_CODE_IN(code), .TEACH_IN(teach),
    .CLOSED_IN(closed), .RELEASE_REQUEST_INPUT_IN(rel), .COMM_MODE_IN(comm),
    .LOCK_COMMAND_BIT_IN(lbit), .AUX_RELEASE_IN(aux), .ELEMENT_STUCK_IN(stuck),
    .TENSION_IN(tens), .SOLENOID_OK_IN(solok), .GATEWAY_LINKED_IN(gw),
    .INTERNAL_FAULT_IN(flt), .COMM_DATA_IN(cdata), .SUPPLY_OK_IN(sup), .ENERGIZE_OUT(),
    .SAFE_OUTPUT_A_OUT(), .SAFE_OUTPUT_B_OUT(), .LOCK_STATE_FLAG_OUT(lck_any),
    .DOOR_CLOSED_FLAG_OUT(), .FAULT_FLAG_OUT(), .FAULT_INDICATOR_OUT(),
    .OUTPUTS_ACTIVE_FLAG_OUT(), .STUCK_ELEMENT_FLAG_OUT(), .COMM_OUT(),
    .TAUGHT_CODE_OUT());
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_lck(input logic v);
    int i;
    i = 0;
    while (lck !== v && i < 300) begin
      cyc(1);
      i++;
    end
  endtask
  task automatic outs(input logic l, input logic d);
    chk("lock", lck, l);
    chk("safe_a", sa, l);
    chk("safe_b", sb, l);
    chk("active", oact, l);
    chk("door", door, d);
  endtask
  task automatic insert(input logic [31:0] c);
    closed = 1;
    near = 1;
    tvalid = 1;
    code = c;
    cyc(20);
    chk("energize", ener, 1);
    chk("safe_a", sa, 0);
  endtask
  task automatic open_g;
    closed = 0;
    near = 0;
    tvalid = 0;
    cyc(12);
    outs(0, 0);
  endtask
  task automatic s_teach;
    want = 0;
    teach = 1;
    insert(GOOD);
    cyc(200);
    teach = 0;
    chk("taught", taught, GOOD);
    open_g();
  endtask
  task automatic s_lock;
    want = 1;
    insert(GOOD ^ 32'h0000_0100);
    cyc(250);
    outs(0, 1);
    chk("lock_any", lck_any, 1);
    code = GOOD;
    wait_lck(1);
    cyc(2);
    outs(1, 1);
  endtask
  task automatic s_release;
    want = 0;
    wait_lck(0);
    cyc(2);
    outs(0, 1);
    want = 1;
    wait_lck(1);
    solok = 0;
    want = 0;
    cyc(30);
    outs(1, 1);
    solok = 1;
    wait_lck(0);
    cyc(2);
    outs(0, 1);
    open_g();
  endtask
  task automatic s_open_req;
    want = 0;
    insert(GOOD);
    cyc(250);
    outs(0, 1);
    want = 1;
    wait_lck(1);
    cyc(2);
    outs(1, 1);
  endtask
  task automatic s_aux;
    aux = 1;
    cyc(12);
    chk("lock", lck, 0);
    chk("safe_b", sb, 0);
    chk("plaus", perr, 1);
    aux = 0;
    cyc(12);
    chk("lock", lck, 0);
    want = 0;
    open_g();
  endtask
  task automatic s_comm;
    comm = 1;
    want = 1;
    insert(GOOD);
    wait_lck(1);
    cyc(2);
    outs(1, 1);
    chk("comm", cout, 1);
    gw = 1;
    want = 0;
    wait_lck(0);
    cyc(2);
    outs(0, 1);
    cyc(4);
    chk("comm", cout, 0);
    cdata = 8'h07;
    cyc(2);
    chk("comm", cout, 1);
    comm = 0;
    want = 1;
    wait_lck(1);
  endtask
  task automatic s_supply;
    sup = 0;
    cyc(12);
    chk("lock", lck, 1);
    sup = 1;
    cyc(12);
    outs(1, 1);
    open_g();
    sup = 0;
    insert(GOOD);
    cyc(150);
    chk("lock", lck, 0);
    sup = 1;
  endtask
  task automatic s_stuck_fault;
    stuck = 1;
    tens = 1;
    cyc(12);
    chk("stuck", sflag, 1);
    stuck = 0;
    tens = 0;
    cyc(12);
    chk("stuck", sflag, 0);
    flt = 1;
    cyc(12);
    chk("safe_a", sa, 0);
    chk("indicator", find, 1);
    chk("fault", fflag, 1);
    flt = 0;
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    error_cnt++;
    conclude();
  end
  initial begin
    cyc(5);
    rst = 0;
    cyc(8);
    outs(0, 0);
    chk("taught", taught, 32'h0);
    s_teach();
    s_lock();
    s_release();
    s_open_req();
    s_aux();
    s_comm();
    s_supply();
    s_stuck_fault();
    conclude();
  end
endmodule
